// file: rtl/lmac_core.sv
/*
  Media access core: receive deserializer with frame sync, CRC check,
  address filter, 16-byte FIFO with local DMA, transmit serializer with
  preamble, jam and backoff, plus config pins for irq, cable and boot PROM.
  Assumes link pins (clocks, carrier, data, collision) are asynchronous and
  that buffer memory answers a DMA read in the cycle after the strobe.
*/
// Notes on behaviour
// - Shift receive bits only while carrier present
// - Delimiter detection fixes receive byte boundaries
// - Each eighth bit counts byte, pushes it unless frame dropped
// - Filter six address bytes; reject clears FIFO
// - Transmit CRC after delimiter, sent MSB first
// - Receive CRC mismatch flags error, rejects packet
// - Send 62 preamble bits then 1,1
// - Collision sends 32 bits of ones
// - Unicast needs all six station bytes equal
// - Multicast other than all-ones accepted only when hashed bit set
// - All-ones destination is broadcast, accepted
// - Thirteenth byte flags overrun; thirteen usable
// - Byte mode requests at threshold plus one
// - Word mode requests at threshold plus two
// - First receive request waits for eight bytes
// - End: burst, flush, header, then release
// - Prefetch threshold bytes; next request after delimiter
// - FIFO read outside loopback hangs host ready
// - Backoff after collision; strip preamble on receive
// - Drive only the selected interrupt line
// - Thin output follows cable selection
// - PROM select, data buffering, gated writes
`timescale 1ns/1ns
module lmac_core #(
  parameter int LEN_W = 11
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic chrdy,
  input wire logic rx_clk,
  input wire logic rx_crs,
  input wire logic rx_d,
  input wire logic tx_clk,
  input wire logic col,
  output logic tx_en,
  output logic tx_data,
  output logic ldma_req,
  input wire logic ldma_gnt,
  output logic ldma_wr,
  output logic ldma_rd,
  output logic [LEN_W-1:0] ldma_ofs,
  output logic [7:0] ldma_wdata,
  input wire logic [7:0] ldma_rdata,
  input wire logic irq_src,
  output logic [7:0] irq_out,
  output logic [7:0] irq_oe,
  output logic thin,
  input wire logic prom_sel,
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_prom_rdata,
  output logic prom_cs,
  output logic prom_we_n,
  output logic [7:0] prom_d_out,
  output logic prom_d_oe,
  input wire logic [7:0] prom_d_in
);
  typedef struct packed {
    logic [4:0] s1, s2, s3;
    logic [5:0][7:0] sta;
    logic [7:0][7:0] mcf;
    logic [7:0] cfga, cfgb, ctrl, stat, rdata;
    logic [LEN_W-1:0] txlen;
    logic [15:0][7:0] mem;
    logic [3:0] wp, rp;
    logic [4:0] cnt;
    logic rsync, rprev, rdrop, mc, bc_all, dmatch, eop, first;
    logic [2:0] rbit, dac;
    logic [7:0] rsh;
    logic [31:0] rcrc;
    logic [LEN_W-1:0] rbc, wofs, lofs, txf, tsent;
    lmac_pkg::lmac_dst_t dst;
    logic req, wr, rd, rdv, txgo, retry, tgo, sfd_done, hang, irqq, txen, txd;
    logic [3:0] bc;
    logic [1:0] hc;
    logic [7:0] wdata, tsh;
    lmac_pkg::lmac_tst_t tst;
    logic [8:0] tcnt;
    logic [2:0] tbit;
    logic [31:0] tcrc;
    logic [4:0] att;
    logic [9:0] bo, lfsr;
  } lmac_st_t;

  lmac_st_t s, n;
  logic push, pop, flush, rej_now, re, te, rbitv, txact, rhit;
  logic [7:0] pdata, stset, stclr, b;
  logic [3:0] thr;
  logic [4:0] room;

  // Serial CRC step, shared by receive and transmit
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic d);
    crc_step = {c[30:0], 1'b0} ^ ((c[31] ^ d) ? lmac_pkg::CRC_POLY : 32'h00000000);
  endfunction

  // Backoff window mask, capped at ten doublings
  function automatic logic [9:0] bo_mask(input logic [4:0] a);
    logic [4:0] k;
    k = (a > lmac_pkg::BO_LIM) ? lmac_pkg::BO_LIM : a;
    bo_mask = 10'h3ff >> (lmac_pkg::BO_LIM - k);
  endfunction

  always_comb begin
    n = s;
    push = 1'b0;
    pop = 1'b0;
    flush = 1'b0;
    rej_now = 1'b0;
    pdata = 8'h00;
    stset = 8'h00;
    stclr = 8'h00;
    b = 8'h00;
    n.wr = 1'b0;
    n.rd = 1'b0;
    n.txgo = s.txgo;
    thr = s.ctrl[7:4];
    room = lmac_pkg::FIFO_OVR - 5'h01 - s.cnt;
    txact = (s.tst != lmac_pkg::T_IDLE) || (s.dst == lmac_pkg::D_PREF) || (s.dst == lmac_pkg::D_TXB);
    // Pin synchronisers; third stage only for edge finding
    n.s1 = {col, tx_clk, rx_d, rx_crs, rx_clk};
    n.s2 = s.s1;
    n.s3 = s.s2;
    re = s.s2[0] & ~s.s3[0];
    te = s.s2[3] & ~s.s3[3];
    rbitv = s.s2[2];
    n.lfsr = {s.lfsr[8:0], s.lfsr[9] ^ s.lfsr[6]};
    n.irqq = irq_src;

    // Register writes
    n.rdata = 8'h00;
    if (reg_wr) begin
      if (reg_addr < lmac_pkg::R_MCF0) begin
        n.sta[reg_addr[2:0]] = reg_wdata;
      end else if (reg_addr < lmac_pkg::R_CFGA) begin
        n.mcf[3'(reg_addr - lmac_pkg::R_MCF0)] = reg_wdata;
      end else begin
        case (reg_addr)
          lmac_pkg::R_CFGA: n.cfga = reg_wdata;
          lmac_pkg::R_CFGB: n.cfgb = reg_wdata;
          lmac_pkg::R_CTRL: begin
            n.ctrl = reg_wdata & ~(8'h01 << lmac_pkg::CTRL_TXGO);
            n.txgo = s.txgo | reg_wdata[lmac_pkg::CTRL_TXGO];
          end
          lmac_pkg::R_STAT: stclr = reg_wdata;
          lmac_pkg::R_TXLL: n.txlen[7:0] = reg_wdata;
          lmac_pkg::R_TXLH: n.txlen[LEN_W-1:8] = reg_wdata[LEN_W-9:0];
          default: ;
        endcase
      end
    end
    // Register reads, data one cycle later
    if (reg_rd) begin
      if (reg_addr < lmac_pkg::R_MCF0) begin
        n.rdata = s.sta[reg_addr[2:0]];
      end else if (reg_addr < lmac_pkg::R_CFGA) begin
        n.rdata = s.mcf[3'(reg_addr - lmac_pkg::R_MCF0)];
      end else begin
        case (reg_addr)
          lmac_pkg::R_CFGA: n.rdata = s.cfga;
          lmac_pkg::R_CFGB: n.rdata = s.cfgb;
          lmac_pkg::R_CTRL: n.rdata = s.ctrl;
          lmac_pkg::R_STAT: n.rdata = s.stat | (8'(txact) << lmac_pkg::ST_TXBUSY);
          lmac_pkg::R_RXCL: n.rdata = s.rbc[7:0];
          lmac_pkg::R_RXCH: n.rdata = 8'(s.rbc[LEN_W-1:8]);
          lmac_pkg::R_TXLL: n.rdata = s.txlen[7:0];
          lmac_pkg::R_TXLH: n.rdata = 8'(s.txlen[LEN_W-1:8]);
          lmac_pkg::R_FIFO: begin
            if (s.ctrl[lmac_pkg::CTRL_LOOP]) begin
              n.rdata = s.mem[s.rp];
              pop = (s.cnt != 5'h00);
            end else begin
              n.hang = 1'b1;
            end
          end
          default: n.rdata = 8'h00;
        endcase
      end
    end

    // Receive deserializer, bits taken on receive clock edges under carrier
    if (s.rsync && !s.s2[1]) begin
      n.rsync = 1'b0;
      if (!s.rdrop) begin
        if (s.dac == lmac_pkg::DA_BYTES && s.rcrc == lmac_pkg::CRC_RES) begin
          n.eop = 1'b1;
          stset[lmac_pkg::ST_RXOK] = 1'b1;
        end else begin
          stset[lmac_pkg::ST_CRCERR] = 1'b1;
          stset[lmac_pkg::ST_REJ] = 1'b1;
          flush = 1'b1;
        end
      end
    end else if (re && s.s2[1] && s.ctrl[lmac_pkg::CTRL_RXEN] && !txact && !s.eop) begin
      if (!s.rsync) begin
        n.rprev = rbitv;
        if (s.rprev && rbitv) begin
          n.rsync = 1'b1;
          n.rbit = 3'h0;
          n.rcrc = 32'hffffffff;
          n.rbc = '0;
          n.dac = 3'h0;
          n.dmatch = 1'b1;
          n.bc_all = 1'b1;
          n.rdrop = 1'b0;
          n.first = 1'b1;
          n.wofs = LEN_W'(lmac_pkg::HDR_BYTES);
          flush = 1'b1;
        end
      end else begin
        n.rcrc = crc_step(s.rcrc, rbitv);
        n.rsh = {rbitv, s.rsh[7:1]};
        n.rbit = 3'(s.rbit + 3'h1);
        if (s.rbit == 3'h7) begin
          b = {rbitv, s.rsh[7:1]};
          n.rbc = LEN_W'(s.rbc + 1'b1);
          if (!s.rdrop) begin
            push = 1'b1;
            pdata = b;
          end
          if (s.dac < lmac_pkg::DA_BYTES) begin
            n.dac = 3'(s.dac + 3'h1);
            n.dmatch = s.dmatch & (b == s.sta[s.dac]);
            n.bc_all = s.bc_all & (b == 8'hff);
            if (s.dac == 3'h0) begin
              n.mc = b[0];
            end
            if (s.dac == lmac_pkg::DA_BYTES - 3'h1) begin
              // Filter decision on the sixth address byte
              if (!(n.bc_all || (s.mc ? s.mcf[n.rcrc[31:29]][n.rcrc[28:26]] : n.dmatch))) begin
                n.rdrop = 1'b1;
                rej_now = 1'b1;
                flush = 1'b1;
                push = 1'b0;
                stset[lmac_pkg::ST_REJ] = 1'b1;
              end
            end
          end
        end
      end
    end

    // Local DMA request thresholds
    if (s.first) begin
      rhit = s.cnt >= lmac_pkg::FIRST_REQ;
    end else if (s.ctrl[lmac_pkg::CTRL_WORD]) begin
      rhit = s.cnt >= 5'({1'b0, thr} + 5'h02);
    end else begin
      rhit = s.cnt >= 5'({1'b0, thr} + 5'h01);
    end
    // Buffer read data stands in the cycle after the strobe
    n.rdv = s.rd;
    if (s.rdv) begin
      push = 1'b1;
      pdata = ldma_rdata;
    end

    // Local DMA sequencer
    unique case (s.dst)
      lmac_pkg::D_IDLE: begin
        if (s.eop) begin
          n.req = 1'b1;
          n.dst = lmac_pkg::D_FLUSH;
        end else if ((s.txgo || s.retry) && !txact) begin
          n.req = 1'b1;
          n.dst = lmac_pkg::D_PREF;
          n.bc = thr;
          n.txf = '0;
          // A go written in this very cycle is kept for the next frame
          n.txgo = reg_wr && (reg_addr == lmac_pkg::R_CTRL) && reg_wdata[lmac_pkg::CTRL_TXGO];
          n.retry = 1'b0;
          flush = 1'b1;
        end else if (s.rsync && !s.rdrop && rhit) begin
          n.req = 1'b1;
          n.dst = lmac_pkg::D_BURST;
          n.bc = thr;
        end else if (s.sfd_done && s.txf < s.txlen && {1'b0, thr} <= room) begin
          n.req = 1'b1;
          n.dst = lmac_pkg::D_TXB;
          n.bc = thr;
        end
      end
      lmac_pkg::D_BURST: begin
        if (s.bc == 4'h0 || s.rdrop || (!s.rsync && !s.eop)) begin
          n.first = 1'b0;
          if (s.eop && !s.rdrop) begin
            n.dst = lmac_pkg::D_FLUSH;
          end else begin
            n.req = 1'b0;
            n.dst = lmac_pkg::D_IDLE;
          end
        end else if (ldma_gnt && s.cnt != 5'h00) begin
          pop = 1'b1;
          n.wr = 1'b1;
          n.wdata = s.mem[s.rp];
          n.lofs = s.wofs;
          n.wofs = LEN_W'(s.wofs + 1'b1);
          n.bc = 4'(s.bc - 4'h1);
        end
      end
      lmac_pkg::D_FLUSH: begin
        if (s.cnt == 5'h00) begin
          n.dst = lmac_pkg::D_PREP;
        end else if (ldma_gnt) begin
          pop = 1'b1;
          n.wr = 1'b1;
          n.wdata = s.mem[s.rp];
          n.lofs = s.wofs;
          n.wofs = LEN_W'(s.wofs + 1'b1);
        end
      end
      lmac_pkg::D_PREP: begin
        n.hc = 2'h0;
        n.dst = lmac_pkg::D_HDR;
      end
      lmac_pkg::D_HDR: begin
        if (ldma_gnt) begin
          n.wr = 1'b1;
          n.lofs = LEN_W'(s.hc);
          n.hc = 2'(s.hc + 2'h1);
          case (s.hc)
            2'h0: n.wdata = s.stat;
            2'h1: n.wdata = 8'h00;
            2'h2: n.wdata = s.rbc[7:0];
            default: n.wdata = 8'(s.rbc[LEN_W-1:8]);
          endcase
          if (s.hc == lmac_pkg::HDR_LAST) begin
            n.req = 1'b0;
            n.eop = 1'b0;
            n.dst = lmac_pkg::D_IDLE;
          end
        end
      end
      lmac_pkg::D_PREF, lmac_pkg::D_TXB: begin
        if ((s.bc == 4'h0 || s.txf == s.txlen) && !s.rd && !s.rdv) begin
          n.req = 1'b0;
          n.dst = lmac_pkg::D_IDLE;
          n.tgo = s.tgo | (s.dst == lmac_pkg::D_PREF);
        end else if (ldma_gnt && s.bc != 4'h0 && s.txf < s.txlen) begin
          n.rd = 1'b1;
          n.lofs = s.txf;
          n.txf = LEN_W'(s.txf + 1'b1);
          n.bc = 4'(s.bc - 4'h1);
        end
      end
    endcase

    // Transmit serializer on transmit clock edges
    if (te) begin
      if (s.s2[4] && (s.tst == lmac_pkg::T_PRE || s.tst == lmac_pkg::T_SFD ||
          s.tst == lmac_pkg::T_DATA || s.tst == lmac_pkg::T_FCS)) begin
        n.tst = lmac_pkg::T_JAM;
        n.tcnt = 9'h001; // Entry bit is the first jam bit
        n.txd = 1'b1;
        stset[lmac_pkg::ST_COL] = 1'b1;
      end else begin
        unique case (s.tst)
          lmac_pkg::T_IDLE: begin
            n.txen = 1'b0;
            n.txd = 1'b0;
            if (s.tgo) begin
              n.tgo = 1'b0;
              n.tst = lmac_pkg::T_PRE;
              n.tcnt = 9'h000;
            end
          end
          lmac_pkg::T_PRE: begin
            n.txen = 1'b1;
            n.txd = ~s.tcnt[0];
            n.tcnt = 9'(s.tcnt + 9'h001);
            if (s.tcnt == lmac_pkg::PRE_BITS - 9'h001) begin
              n.tst = lmac_pkg::T_SFD;
              n.tcnt = 9'h000;
            end
          end
          lmac_pkg::T_SFD: begin
            n.txd = 1'b1;
            n.tcnt = 9'(s.tcnt + 9'h001);
            if (s.tcnt == 9'h001) begin
              n.tst = lmac_pkg::T_DATA;
              n.tbit = 3'h0;
              n.tcrc = 32'hffffffff;
              n.tsent = '0;
              n.sfd_done = 1'b1;
            end
          end
          lmac_pkg::T_DATA: begin
            b = (s.tbit == 3'h0) ? s.mem[s.rp] : s.tsh;
            pop = pop | ((s.tbit == 3'h0) && s.cnt != 5'h00);
            n.txd = b[0];
            n.tsh = {1'b0, b[7:1]};
            n.tcrc = crc_step(s.tcrc, b[0]);
            n.tbit = 3'(s.tbit + 3'h1);
            if (s.tbit == 3'h7) begin
              n.tsent = LEN_W'(s.tsent + 1'b1);
              if (LEN_W'(s.tsent + 1'b1) >= s.txlen) begin
                n.tst = lmac_pkg::T_FCS;
                n.tcnt = 9'h000;
              end
            end
          end
          lmac_pkg::T_FCS: begin
            n.txd = ~s.tcrc[31];
            n.tcrc = {s.tcrc[30:0], 1'b0};
            n.tcnt = 9'(s.tcnt + 9'h001);
            if (s.tcnt == lmac_pkg::FCS_BITS - 9'h001) begin
              n.tst = lmac_pkg::T_IDLE;
              n.sfd_done = 1'b0;
              n.att = 5'h00;
              stset[lmac_pkg::ST_TXOK] = 1'b1;
            end
          end
          lmac_pkg::T_JAM: begin
            n.txd = 1'b1;
            n.tcnt = 9'(s.tcnt + 9'h001);
            if (s.tcnt == lmac_pkg::JAM_BITS - 9'h001) begin
              n.att = 5'(s.att + 5'h01);
              n.bo = s.lfsr & bo_mask(5'(s.att + 5'h01));
              n.tcnt = 9'h000;
              n.sfd_done = 1'b0;
              n.tst = (5'(s.att + 5'h01) == lmac_pkg::MAX_ATT) ? lmac_pkg::T_IDLE : lmac_pkg::T_BACK;
            end
          end
          lmac_pkg::T_BACK: begin
            n.txen = 1'b0;
            n.txd = 1'b0;
            if (s.bo == 10'h000) begin
              n.retry = 1'b1;
              n.tst = lmac_pkg::T_IDLE;
            end else begin
              n.tcnt = 9'(s.tcnt + 9'h001);
              if (s.tcnt == lmac_pkg::SLOT_BITS) begin
                n.bo = 10'(s.bo - 10'h001);
                n.tcnt = 9'h000;
              end
            end
          end
        endcase
      end
    end

    // FIFO update; overrun on the thirteenth byte
    if (push && s.cnt == lmac_pkg::FIFO_OVR - 5'h01) begin
      stset[lmac_pkg::ST_OVR] = 1'b1;
    end
    if (flush) begin
      n.wp = 4'h0;
      n.rp = 4'h0;
      n.cnt = 5'h00;
    end else begin
      push = push && (s.cnt < lmac_pkg::FIFO_OVR);
      if (push) begin
        n.mem[s.wp] = pdata;
        n.wp = 4'(s.wp + 4'h1);
      end
      if (pop) begin
        n.rp = 4'(s.rp + 4'h1);
      end
      n.cnt = 5'(s.cnt + {4'h0, push} - {4'h0, pop});
    end
    // Sticky status; a set wins over a clear
    n.stat = (s.stat & ~stclr) | stset;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.ctrl <= lmac_pkg::CTRL_RST;
      s.first <= 1'b1;
      s.wofs <= LEN_W'(lmac_pkg::HDR_BYTES);
      s.lfsr <= lmac_pkg::LFSR_RST;
      s.dst <= lmac_pkg::D_IDLE;
      s.tst <= lmac_pkg::T_IDLE;
    end else begin
      s <= n;
    end
  end

  // Outputs
  assign reg_rdata = s.rdata;
  assign chrdy = ~s.hang;
  assign tx_en = s.txen;
  assign tx_data = s.txd;
  assign ldma_req = s.req;
  assign ldma_wr = s.wr;
  assign ldma_rd = s.rd;
  assign ldma_ofs = s.lofs;
  assign ldma_wdata = s.wdata;
  assign irq_out = {8{s.irqq}};
  assign irq_oe = 8'h01 << s.cfga[2:0];
  assign thin = (s.cfgb[1:0] == lmac_pkg::CABLE_THIN);
  // Boot PROM select and data buffering
  assign prom_cs = prom_sel;
  assign prom_d_oe = prom_sel & host_wr & s.cfgb[lmac_pkg::CFGB_PROMWE];
  assign prom_we_n = ~prom_d_oe;
  assign prom_d_out = host_wdata;
  assign host_prom_rdata = prom_d_in;

  // Checks
  sequence s_prep_hdr;
    (s.dst == lmac_pkg::D_PREP) ##1 (s.dst == lmac_pkg::D_HDR);
  endsequence
  property p_flush_order;
    @(posedge clk) disable iff (!rst_n) (s.dst == lmac_pkg::D_FLUSH && s.cnt == 5'h00) |=> s_prep_hdr;
  endproperty
  a_flush_order: assert property (p_flush_order) else $error("flush not followed by header");
  property p_hang;
    @(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr == lmac_pkg::R_FIFO && !s.ctrl[lmac_pkg::CTRL_LOOP]) |=> !chrdy [*8];
  endproperty
  a_hang: assert property (p_hang) else $error("ready returned after FIFO read");
  property p_irq;
    @(posedge clk) disable iff (!rst_n) $onehot(irq_oe) && irq_oe[s.cfga[2:0]];
  endproperty
  a_irq: assert property (p_irq) else $error("wrong interrupt line driven");
  property p_ovr;
    @(posedge clk) disable iff (!rst_n) (push && !flush && s.cnt == 5'h0c) |=> s.stat[lmac_pkg::ST_OVR];
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");
  property p_cnt;
    @(posedge clk) disable iff (!rst_n) s.cnt <= lmac_pkg::FIFO_OVR;
  endproperty
  a_cnt: assert property (p_cnt) else $error("FIFO above thirteen");
  property p_first;
    @(posedge clk) disable iff (!rst_n) ($rose(ldma_req) && s.dst == lmac_pkg::D_BURST && s.first) |-> s.cnt >= 5'h08;
  endproperty
  a_first: assert property (p_first) else $error("early first request");
  property p_jam;
    @(posedge clk) disable iff (!rst_n) (s.tst == lmac_pkg::T_JAM) |-> (tx_data && tx_en);
  endproperty
  a_jam: assert property (p_jam) else $error("jam bit not one");
  property p_pre;
    @(posedge clk) disable iff (!rst_n)
      $rose(s.tst == lmac_pkg::T_SFD) |-> $past(s.tcnt) == 9'h03d && !tx_data ##0 (s.tst == lmac_pkg::T_SFD);
  endproperty
  a_pre: assert property (p_pre) else $error("preamble length wrong");
  property p_rej;
    @(posedge clk) disable iff (!rst_n) rej_now |=> (s.cnt == 5'h00 && s.rdrop);
  endproperty
  a_rej: assert property (p_rej) else $error("rejected frame left data");
  property p_thin;
    @(posedge clk) disable iff (!rst_n) $changed(s.cfgb[1:0]) |-> thin == (s.cfgb[1:0] == 2'h1);
  endproperty
  a_thin: assert property (p_thin) else $error("thin output wrong");
endmodule

// file: rtl/lmac_pkg.sv
/*
  Shared constants for the network media access core: register offsets,
  field positions, reset values, protocol counts and state encodings.
  Assumes an 8-bit register port with a 5-bit byte address.
*/
package lmac_pkg;
  // Register offsets
  localparam logic [4:0] R_STA0 = 5'h00;
  localparam logic [4:0] R_MCF0 = 5'h06;
  localparam logic [4:0] R_CFGA = 5'h0e;
  localparam logic [4:0] R_CFGB = 5'h0f;
  localparam logic [4:0] R_CTRL = 5'h10;
  localparam logic [4:0] R_STAT = 5'h11;
  localparam logic [4:0] R_RXCL = 5'h12;
  localparam logic [4:0] R_RXCH = 5'h13;
  localparam logic [4:0] R_TXLL = 5'h14;
  localparam logic [4:0] R_TXLH = 5'h15;
  localparam logic [4:0] R_FIFO = 5'h16;
  // Field positions
  localparam int CTRL_RXEN = 0;
  localparam int CTRL_WORD = 1;
  localparam int CTRL_TXGO = 2;
  localparam int CTRL_LOOP = 3;
  localparam int CFGB_PROMWE = 2;
  localparam int ST_RXOK = 0;
  localparam int ST_CRCERR = 1;
  localparam int ST_REJ = 2;
  localparam int ST_OVR = 3;
  localparam int ST_TXOK = 4;
  localparam int ST_COL = 5;
  localparam int ST_TXBUSY = 6;
  localparam logic [1:0] CABLE_THIN = 2'h1;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h80;
  localparam logic [9:0] LFSR_RST = 10'h2a5;
  // Protocol counts
  localparam logic [4:0] FIFO_OVR = 5'h0d;
  localparam logic [4:0] FIRST_REQ = 5'h08;
  localparam logic [8:0] PRE_BITS = 9'h03e;
  localparam logic [8:0] JAM_BITS = 9'h020;
  localparam logic [8:0] SLOT_BITS = 9'h1ff;
  localparam logic [8:0] FCS_BITS = 9'h020;
  localparam logic [4:0] BO_LIM = 5'h0a;
  localparam logic [4:0] MAX_ATT = 5'h10;
  localparam logic [2:0] DA_BYTES = 3'h6;
  localparam logic [1:0] HDR_LAST = 2'h3;
  localparam logic [10:0] HDR_BYTES = 11'h004;
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_RES = 32'hc704dd7b;
  // Local DMA states
  typedef enum logic [6:0] {
    D_IDLE = 7'b0000001, D_BURST = 7'b0000010, D_FLUSH = 7'b0000100, D_PREP = 7'b0001000,
    D_HDR = 7'b0010000, D_PREF = 7'b0100000, D_TXB = 7'b1000000
  } lmac_dst_t;
  // Transmit serializer states
  typedef enum logic [6:0] {
    T_IDLE = 7'b0000001, T_PRE = 7'b0000010, T_SFD = 7'b0000100, T_DATA = 7'b0001000,
    T_FCS = 7'b0010000, T_JAM = 7'b0100000, T_BACK = 7'b1000000
  } lmac_tst_t;
endpackage

// file: testbench/lmac_far.sv
/*
  Far side model: buffer memory with grant and read data, plus the
  encoder's free-running transmit bit clock at 400 ns.
  Assumes read data is wanted in the cycle after the read strobe.
*/
`timescale 1ns/1ns
module lmac_far (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ldma_req,
  input wire logic ldma_rd,
  input wire logic [10:0] ldma_ofs,
  output logic ldma_gnt,
  output logic [7:0] ldma_rdata,
  output logic tx_clk
);
  // Encoder bit clock
  initial begin
    tx_clk = 1'b0;
    forever #200 tx_clk = ~tx_clk;
  end
  // Grant one cycle late; data only after a read, else toggling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ldma_gnt <= 1'b0;
      ldma_rdata <= 8'h00;
    end else begin
      ldma_gnt <= ldma_req;
      ldma_rdata <= ldma_rd ? {ldma_ofs[4:0], 3'h5} : ~ldma_rdata;
    end
  end
endmodule

// file: testbench/test_lmac_core.sv
/*
  Self-checking bench for the media access core: config pins, registers,
  a rejected receive frame, transmit preamble and data, collision jam
  and the host hang on a FIFO read.
  Assumes the far side model in lmac_far.sv.
*/
`timescale 1ns/1ns
module test_lmac_core;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, irq_src = 0, prom_sel = 0, host_wr = 0;
  logic rx_clk = 0, rx_crs = 0, rx_d = 0, col = 0, prom_cs, prom_we_n, ldma_wr;
  logic [7:0] irq_out, host_prom_rdata, prom_d_in = 0;
  logic [4:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, host_wdata = 0, d, r, ldma_rdata, irq_oe, prom_d_out, reg_rdata;
  logic [10:0] ldma_ofs;
  logic chrdy, tx_clk, tx_en, tx_data, ldma_req, ldma_gnt, ldma_rd, thin, prom_d_oe;
  integer fail_count = 0, tests_run = 0, seed = 32'h571d, cyc = 0, k;
  lmac_core lmac_core_inst (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .chrdy,
    .rx_clk, .rx_crs, .rx_d, .tx_clk, .col, .tx_en, .tx_data, .ldma_req,
    .ldma_gnt, .ldma_wr, .ldma_rd, .ldma_ofs, .ldma_wdata(), .ldma_rdata, .irq_src, .irq_out,
    .irq_oe, .thin, .prom_sel, .host_wr, .host_wdata, .host_prom_rdata, .prom_cs, .prom_we_n,
    .prom_d_out, .prom_d_oe, .prom_d_in);
  lmac_far lmac_far_inst (.clk, .rst_n, .ldma_req, .ldma_rd, .ldma_ofs, .ldma_gnt, .ldma_rdata, .tx_clk);
  // Core clock and hang guard
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      results;
    end
  end
  // Compare and bus tasks
  task chk(input logic [7:0] g, input logic [7:0] e);
    tests_run = tests_run + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [4:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // One receive bit, 400 ns link clock, data set on the falling side
  task rxbit(input logic v);
    rx_clk <= 1'b0;
    rx_d <= v;
    repeat (4) @(posedge clk);
    rx_clk <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task results;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(lmac_pkg::R_CTRL, r); chk(r, 8'h80);
    rd(5'h1f, r); chk(r, 8'h00);
    d = $random(seed);
    wr(lmac_pkg::R_STA0, d); rd(lmac_pkg::R_STA0, r); chk(r, d);
    for (k = 0; k < 8; k++) begin
      d = $random(seed);
      irq_src <= d[0];
      wr(lmac_pkg::R_CFGA, k[7:0]); chk(irq_oe, 8'h01 << k);
      chk(irq_out, {8{irq_src}});
    end
    for (k = 0; k < 8; k++) begin
      d = $random(seed);
      prom_sel <= 1'b1; host_wr <= 1'b1; host_wdata <= d; prom_d_in <= ~d;
      wr(lmac_pkg::R_CFGB, {5'h00, k[2:0]});
      chk({7'h00, thin}, {7'h00, k[1:0] == 2'h1});
      chk({7'h00, prom_d_oe}, {7'h00, k[2]}); chk(prom_d_out, d);
      chk(host_prom_rdata, ~d);
      chk({6'h00, prom_cs, prom_we_n}, {6'h00, 1'b1, ~k[2]});
    end
    // Receive: preamble, 1,1, destination 02 10 00 00 00 00 misses the station
    wr(lmac_pkg::R_CTRL, 8'h81); rx_crs <= 1'b1;
    for (k = 0; k < 112; k++) rxbit((k < 62) ? ~k[0] : (k < 64 || k == 65 || k == 76));
    rx_crs <= 1'b0; rx_clk <= 1'b0; repeat (8) @(posedge clk);
    chk({7'h00, ldma_req | ldma_wr}, 8'h00);
    rd(lmac_pkg::R_STAT, r); chk(r, 8'h04);
    rd(lmac_pkg::R_RXCL, r); chk(r, 8'h06);
    // Send a frame: threshold 8, 64 bytes
    wr(lmac_pkg::R_TXLL, 8'h40); wr(lmac_pkg::R_TXLH, 8'h00); wr(lmac_pkg::R_CTRL, 8'h84);
    k = 0;
    while (tx_en !== 1'b1 && k < 4000) begin
      @(posedge clk); k++;
    end
    chk({7'h00, tx_en}, 8'h01);
    d = 8'h05; // Far model data at offset 0
    for (k = 0; k < 72; k++) begin
      @(negedge tx_clk);
      if (k < 64) chk({7'h00, tx_data}, (k < 62) ? {7'h00, ~k[0]} : 8'h01);
      else chk({7'h00, tx_data}, {7'h00, d[k[2:0]]});
      if (k < 62) chk({7'h00, ldma_req}, 8'h00);
    end
    // Collision in the data: 32 jam ones, then backoff with the line idle
    @(posedge clk); col <= 1'b1;
    for (k = 0; k < 32; k++) begin
      @(negedge tx_clk); chk({7'h00, tx_data}, 8'h01);
    end
    @(posedge clk); col <= 1'b0;
    @(negedge tx_clk); chk({7'h00, tx_en}, 8'h00);
    rd(lmac_pkg::R_STAT, r); chk(r & 8'h3f, 8'h24);
    // FIFO read outside loopback hangs the host
    chk({7'h00, chrdy}, 8'h01);
    rd(lmac_pkg::R_FIFO, r); repeat (2) @(posedge clk);
    chk({7'h00, chrdy}, 8'h00);
    results;
  end
endmodule
